// [rtl/sysref_margin_and_reset_init.sv]
// Setup-margin register, transfer staging and digital reset sequencer
`timescale 1ns/100ps
`default_nettype none
module sysref_margin_and_reset_init
  import margin_reset_pkg::*;
#(
  parameter int INIT_LEN = INIT_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        clockEnable,
  input  wire logic        clockStable,
  input  wire logic        writeStrobe,
  input  wire logic        readStrobe,
  input  wire logic [11:0] regAddr,
  input  wire logic [7:0]  writeData,
  output var  logic [7:0]  readData,
  input  wire logic [10:0] setupSlackPs,
  input  wire logic        sysrefEvent,
  output var  logic        setupViolation,
  output var  logic [10:0] activeMarginPs,
  output var  logic        digitalReset,
  output var  logic        initDone,
  output var  logic        degradedStart
);
  // The init counter is sixteen bits wide
  initial begin
    if (INIT_LEN < 1) $error("INIT_LEN must be at least one");
    if (INIT_LEN > 65535) $error("INIT_LEN exceeds the init counter");
  end

  typedef struct packed {
    init_state_t state;
    logic [15:0] initCount;
    logic        degraded;
    logic [7:0]  resetStaged;
    logic [7:0]  resetActive;
    logic [7:0]  marginStaged;
    logic [7:0]  marginActive;
    logic        violation;
    logic [7:0]  readData;
  } state_t;

  // Power-on contents; margin and reset registers come up cleared
  localparam state_t STATE_RST = '{
    state:        ST_INIT,
    initCount:    16'h0000,
    degraded:     1'b0,
    resetStaged:  8'h00,
    resetActive:  8'h00,
    marginStaged: SETUP_MARGIN_RST,
    marginActive: SETUP_MARGIN_RST,
    violation:    1'b0,
    readData:     8'h00
  };

  // Shared address decode for both strobes
  function automatic logic addrHit(input logic strobe, input logic [11:0] addr, input logic [11:0] target);
    addrHit = strobe && (addr == target);
  endfunction

  state_t cur_reg;
  state_t cur_next;
  logic   wrTransfer;
  logic   wrReset;
  logic   wrMargin;
  logic   rdMapped;

  // Decode kept outside the state process so the checks can see it
  assign wrTransfer = addrHit(writeStrobe, regAddr, ADDR_TRANSFER) && writeData == TRANSFER_CMD;
  assign wrReset    = addrHit(writeStrobe, regAddr, ADDR_RESET);
  assign wrMargin   = addrHit(writeStrobe, regAddr, ADDR_SETUP_MARGIN);
  assign rdMapped   = addrHit(readStrobe, regAddr, ADDR_RESET) || addrHit(readStrobe, regAddr, ADDR_SETUP_MARGIN);

  always_comb begin
    cur_next = cur_reg;
    // Writes during power-up are ignored by the ST_INIT branch and are lost
    case (cur_reg.state)
      ST_INIT: begin
        // Power-up sequence; an unstable clock is remembered, not hidden
        if (!clockStable) cur_next.degraded = 1'b1;
        if (cur_reg.initCount == 16'(INIT_LEN - 1)) begin
          cur_next.state = ST_RUN;
          cur_next.initCount = '0;
        end else begin
          cur_next.initCount = cur_reg.initCount + 16'h0001;
        end
      end
      ST_RUN: begin
        // Staged copies only; active logic waits for the transfer
        if (wrReset) cur_next.resetStaged = writeData;
        if (wrMargin) cur_next.marginStaged = writeData;
        if (wrTransfer) begin
          cur_next.resetActive = cur_reg.resetStaged;
          cur_next.marginActive = cur_reg.marginStaged;
          if (cur_reg.resetStaged == RESET_CMD) cur_next.state = ST_RESET;
        end
      end
      ST_RESET: begin
        // Digital reset held until the clearing write is transferred
        cur_next.degraded = 1'b0;
        cur_next.marginStaged = SETUP_MARGIN_RST;
        cur_next.marginActive = SETUP_MARGIN_RST;
        // Margin writes are dropped here; only the reset and transfer registers listen
        if (wrReset) cur_next.resetStaged = writeData;
        if (wrTransfer) begin
          cur_next.resetActive = cur_reg.resetStaged;
          if (cur_reg.resetStaged != RESET_CMD) cur_next.state = ST_RUN;
        end
      end
      default: cur_next.state = ST_INIT;
    endcase
    // Flag threshold only; capture timing is untouched by the margin
    cur_next.violation = sysrefEvent &&
      (setupSlackPs < margin_ps(cur_reg.marginActive[7:MARGIN_LSB]));
    // Transfer register is write-only and reads as zero
    if (readStrobe) begin
      case (regAddr)
        ADDR_RESET:        cur_next.readData = cur_reg.resetStaged;
        ADDR_SETUP_MARGIN: cur_next.readData = cur_reg.marginStaged;
        default:           cur_next.readData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cur_reg <= STATE_RST;
    end else if (clockEnable) begin
      cur_reg <= cur_next;
    end
  end

  assign readData       = cur_reg.readData;
  assign setupViolation = cur_reg.violation;
  assign activeMarginPs = margin_ps(cur_reg.marginActive[7:MARGIN_LSB]);
  assign digitalReset   = cur_reg.state == ST_RESET;
  assign initDone       = cur_reg.state != ST_INIT;
  assign degradedStart  = cur_reg.degraded;

  chk_margin_holds: assert property (@(posedge clock) disable iff (reset)
    (clockEnable && !wrTransfer && cur_reg.state == ST_RUN) |=> $stable(activeMarginPs))
    else $error("active margin changed without transfer");
  chk_margin_scale: assert property (@(posedge clock) disable iff (reset)
    cur_reg.marginActive[7:5] == 3'b111 |-> activeMarginPs == 11'h0f5)
    else $error("margin code 7 not 245 ps");
  chk_flag_threshold: assert property (@(posedge clock) disable iff (reset)
    (clockEnable && !sysrefEvent) |=> !setupViolation)
    else $error("flag raised without event");
  chk_reset_entry: assert property (@(posedge clock) disable iff (reset)
    (clockEnable && cur_reg.state == ST_RUN && wrTransfer && cur_reg.resetStaged == RESET_CMD) |=> digitalReset)
    else $error("reset not entered");
  chk_reset_clears: assert property (@(posedge clock) disable iff (reset)
    (clockEnable && digitalReset && wrTransfer && cur_reg.resetStaged == 8'h00) |=> !digitalReset)
    else $error("reset not released");
  chk_degraded_seen: assert property (@(posedge clock) disable iff (reset)
    (clockEnable && !initDone && !clockStable) |=> degradedStart)
    else $error("unstable clock not flagged");
  chk_reset_default: assert property (@(posedge clock) disable iff (reset)
    $fell(reset) |-> cur_reg.marginStaged == 8'h00)
    else $error("margin default wrong");
  chk_reset_restart: assert property (@(posedge clock) disable iff (reset)
    (clockEnable && digitalReset) |=> !degradedStart)
    else $error("degraded not cleared");

  // Clock enable, power-up and register access
  chk_freeze_state: assert property (@(posedge clock) disable iff (reset)
    !clockEnable |=> $stable(cur_reg))
    else $error("state moved while clock enable low");
  chk_init_writes: assert property (@(posedge clock) disable iff (reset)
    (clockEnable && !initDone && writeStrobe) |=> $stable(cur_reg.marginStaged) && $stable(cur_reg.resetStaged))
    else $error("write taken during power-up");
  chk_init_length: assert property (@(posedge clock) disable iff (reset)
    (clockEnable && !initDone && cur_reg.initCount == 16'(INIT_LEN - 1)) |=> initDone)
    else $error("power-up did not end");
  chk_init_count: assert property (@(posedge clock) disable iff (reset)
    !initDone |-> cur_reg.initCount < 16'(INIT_LEN))
    else $error("init counter overran");
  chk_run_clean: assert property (@(posedge clock) disable iff (reset)
    (clockEnable && initDone && !degradedStart) |=> !degradedStart)
    else $error("degraded set after power-up");
  chk_margin_staged: assert property (@(posedge clock) disable iff (reset)
    (clockEnable && initDone && !digitalReset && wrMargin) |=> cur_reg.marginStaged == $past(writeData))
    else $error("margin write not staged");
  chk_read_margin: assert property (@(posedge clock) disable iff (reset)
    (clockEnable && addrHit(readStrobe, regAddr, ADDR_SETUP_MARGIN)) |=> readData == $past(cur_reg.marginStaged))
    else $error("margin read wrong");
  chk_read_unmapped: assert property (@(posedge clock) disable iff (reset)
    (clockEnable && readStrobe && !rdMapped) |=> readData == 8'h00)
    else $error("unmapped read not zero");
  chk_read_holds: assert property (@(posedge clock) disable iff (reset)
    !readStrobe |=> $stable(readData))
    else $error("read data moved without read");
  chk_write_unmapped: assert property (@(posedge clock) disable iff (reset)
    (clockEnable && writeStrobe && !wrReset && !wrMargin) |=> $stable(cur_reg.marginStaged) && $stable(cur_reg.resetStaged))
    else $error("unmapped write changed a register");
  chk_transfer_copy: assert property (@(posedge clock) disable iff (reset)
    (clockEnable && initDone && !digitalReset && wrTransfer) |=> cur_reg.marginActive == $past(cur_reg.marginStaged))
    else $error("transfer did not copy margin");

  // Margin scale and flag
  chk_code_zero: assert property (@(posedge clock) disable iff (reset)
    cur_reg.marginActive[7:5] == 3'b000 |-> activeMarginPs == 11'h000)
    else $error("margin code 0 not zero");
  chk_margin_step: assert property (@(posedge clock) disable iff (reset)
    activeMarginPs == 11'(cur_reg.marginActive[7:5]) * 11'h023)
    else $error("margin not 35 ps per code");
  chk_violation_set: assert property (@(posedge clock) disable iff (reset)
    (clockEnable && sysrefEvent && setupSlackPs < activeMarginPs) |=> setupViolation)
    else $error("violation not flagged");

  // Digital reset
  chk_reset_holds: assert property (@(posedge clock) disable iff (reset)
    (clockEnable && digitalReset && !wrTransfer) |=> digitalReset)
    else $error("reset dropped without transfer");
  chk_reset_margin: assert property (@(posedge clock) disable iff (reset)
    (clockEnable && digitalReset) |=> activeMarginPs == 11'h000 && cur_reg.marginStaged == 8'h00)
    else $error("reset left a margin in place");
  cov_init_done: cover property (@(posedge clock) disable iff (reset) $rose(initDone));
  cov_reset_seq: cover property (@(posedge clock) disable iff (reset) $fell(digitalReset));
  cov_violation: cover property (@(posedge clock) disable iff (reset) setupViolation);
  cov_degraded: cover property (@(posedge clock) disable iff (reset) $rose(degradedStart));
  cov_frozen: cover property (@(posedge clock) disable iff (reset) !clockEnable ##1 clockEnable);
endmodule // sysref_margin_and_reset_init
`default_nettype wire

// [rtl/margin_reset_pkg.sv]
// Constants for the setup-margin register and digital reset sequencer
package margin_reset_pkg;
  localparam logic [11:0] ADDR_RESET       = 12'h000;
  localparam logic [11:0] ADDR_TRANSFER    = 12'h080;
  localparam logic [11:0] ADDR_SETUP_MARGIN = 12'h13c;
  localparam logic [7:0]  RESET_CMD        = 8'h3c;
  localparam logic [7:0]  TRANSFER_CMD     = 8'hff;
  localparam logic [7:0]  SETUP_MARGIN_RST = 8'h00;
  localparam int          MARGIN_LSB       = 5;
  localparam int          MARGIN_STEP_PS   = 35;
  localparam int          INIT_CYCLES      = 64;
  localparam int          CLOCK_PERIOD_PS  = 4000;

  typedef enum logic [2:0] {
    ST_INIT  = 3'b001,
    ST_RESET = 3'b010,
    ST_RUN   = 3'b100
  } init_state_t;

  function automatic logic [10:0] margin_ps(input logic [2:0] code);
    margin_ps = 11'(code) * 11'(MARGIN_STEP_PS);
  endfunction
endpackage

// [tb/spi_host_model.sv]
// Host model: register accesses and the digital reset sequence
`timescale 1ns/100ps
`default_nettype none
module spi_host_model
  import margin_reset_pkg::*;
(
  input  wire logic        clock,
  output var  logic        writeStrobe,
  output var  logic        readStrobe,
  output var  logic [11:0] regAddr,
  output var  logic [7:0]  writeData
);
  initial begin
    {writeStrobe, readStrobe, regAddr, writeData} = 22'h0;
  end
  task automatic access(input logic wr, input logic [11:0] a, input logic [7:0] d);
    @(negedge clock);
    {writeStrobe, readStrobe, regAddr, writeData} = {wr, !wr, a, d};
    @(negedge clock);
    // Released lines must not look like a held address
    {writeStrobe, readStrobe, regAddr, writeData} = {2'h0, ~a, ~d};
  endtask
  task automatic resetSeq();
    access(1'b1, ADDR_RESET, RESET_CMD);
    access(1'b1, ADDR_TRANSFER, TRANSFER_CMD);
    access(1'b1, ADDR_RESET, 8'h00);
    access(1'b1, ADDR_TRANSFER, TRANSFER_CMD);
  endtask
endmodule // spi_host_model
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench for the setup-margin register and reset sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import margin_reset_pkg::*;
  logic        clock = 1'b0, reset = 1'b1, clockStable = 1'b0, sysrefEvent = 1'b0, clockEnable = 1'b1;
  logic [10:0] setupSlackPs = 11'h0, activeMarginPs;
  logic        writeStrobe, readStrobe, setupViolation, digitalReset, initDone, degradedStart;
  logic [11:0] regAddr;
  logic [7:0]  writeData, readData;
  int          badCount = 0, nTests = 0, cycles = 0;
  always #2 clock = ~clock;
  spi_host_model hostU (.clock(clock), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .regAddr(regAddr), .writeData(writeData));
  sysref_margin_and_reset_init #(.INIT_LEN(4)) dut_u (.clock(clock), .reset(reset),
    .clockEnable(clockEnable), .clockStable(clockStable), .writeStrobe(writeStrobe), .readStrobe(readStrobe),
    .regAddr(regAddr), .writeData(writeData), .readData(readData), .setupSlackPs(setupSlackPs),
    .sysrefEvent(sysrefEvent), .setupViolation(setupViolation), .activeMarginPs(activeMarginPs),
    .digitalReset(digitalReset), .initDone(initDone), .degradedStart(degradedStart));
  task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
    nTests++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic endOfTest();
    $display("Checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Whole run needs a little over a hundred cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      badCount++;
      endOfTest();
    end
  end
  task automatic sysref(input logic [10:0] slack, input logic exp);
    @(negedge clock);
    {sysrefEvent, setupSlackPs} = {1'b1, slack};
    @(negedge clock);
    {sysrefEvent, setupSlackPs} = {1'b0, ~slack};
    check("setupViolation", 11'(setupViolation), 11'(exp));
  endtask
  initial begin
    repeat (20) @(negedge clock);
    reset = 1'b0;
    for (int i = 0; i < 40 && initDone !== 1'b1; i++) @(negedge clock);
    check("initDone", 11'(initDone), 11'h1);
    check("degradedStart", 11'(degradedStart), 11'h1);
    clockStable = 1'b1;
    hostU.resetSeq();
    check("degradedStart", 11'(degradedStart), 11'h0);
    check("digitalReset", 11'(digitalReset), 11'h0);
    hostU.access(1'b0, ADDR_SETUP_MARGIN, 8'h00);
    check("marginReset", 11'(readData), 11'h0);
    for (int code = 0; code < 8; code++) begin
      hostU.access(1'b1, ADDR_SETUP_MARGIN, {3'(code), 5'h00});
      check("staged", activeMarginPs, 11'((code == 0 ? 0 : code - 1) * MARGIN_STEP_PS));
      hostU.access(1'b1, ADDR_TRANSFER, TRANSFER_CMD);
      @(negedge clock);
      check("activeMargin", activeMarginPs, 11'(code * MARGIN_STEP_PS));
      hostU.access(1'b0, ADDR_SETUP_MARGIN, 8'h00);
      check("readback", 11'(readData), 11'({3'(code), 5'h00}));
    end
    sysref(11'h0f4, 1'b1);
    sysref(11'h0f5, 1'b0);
    hostU.access(1'b0, 12'h055, 8'h00);
    check("unmapped", 11'(readData), 11'h0);
    // Frozen clock enable must hold staged and active settings
    clockEnable = 1'b0;
    hostU.access(1'b1, ADDR_SETUP_MARGIN, 8'h20);
    hostU.access(1'b1, ADDR_TRANSFER, TRANSFER_CMD);
    @(negedge clock);
    check("frozenMargin", activeMarginPs, 11'(7 * MARGIN_STEP_PS));
    clockEnable = 1'b1;
    hostU.access(1'b1, 12'h055, 8'h5a);
    hostU.access(1'b0, ADDR_SETUP_MARGIN, 8'h00);
    check("frozenStaged", 11'(readData), 11'h0e0);
    // Second power-up with a stable clock
    @(negedge clock);
    reset = 1'b1;
    @(negedge clock);
    check("resetMargin", activeMarginPs, 11'h000);
    check("resetInit", 11'(initDone), 11'h0);
    reset = 1'b0;
    for (int i = 0; i < 40 && initDone !== 1'b1; i++) @(negedge clock);
    check("stableStart", 11'(degradedStart), 11'h0);
    hostU.resetSeq();
    check("resetAgain", 11'(digitalReset), 11'h0);
    hostU.access(1'b0, ADDR_SETUP_MARGIN, 8'h00);
    check("marginAfterReset", 11'(readData), 11'h0);
    endOfTest();
  end
endmodule // testbench
`default_nettype wire
